// [ee_wr_map.vh]
// Constants for the two-wire EEPROM write engine.
// Assumes a 10 MHz system clock and inputs already synchronous to it.
//
// Overview of operation
// - Data falling with clock high is start; decoding begins after it.
// - Data rising with clock high is stop; device then drops to standby.
// - Bits sampled on clock rise; outgoing bits driven after clock fall.
// - Words are eight bits; device pulls data low in ninth clock as ack.
// - Standby at power-up and after stop once internal work is done.
// - Address word is 1010, strap bit, two top address bits, read/write.
// - Select bit is compared with the strap input, low when unconnected.
// - One strap bit plus two address bits: at most two devices per bus.
// - Address word bit zero: one starts a read, zero starts a write.
// - Matching address is acked; mismatch gets no ack and goes standby.
// - Array is 1024 pages of 256 bytes, 18-bit word address.
// - Byte write acks address, two address bytes, data; stop programs.
// - During programming all inputs are ignored and nothing answers.
// - Page write takes up to 256 bytes, each acked, ended by stop.
// - Only low eight address bits advance, wrapping inside the page.
// - Write-protect input high protects the whole array from writes.
// - Id page write uses type 1011, bit ten zero, low byte selects.
// - A locked id page gets no ack for any data byte.
// - Address polls are acked only after programming has finished.
// - Programming completes within 8 ms of the terminating stop.
`ifndef EE_WR_MAP_VH
`define EE_WR_MAP_VH

// Device type codes in the top nibble of the address word
`define EE_TYPE_ARRAY 4'ha
`define EE_TYPE_IDPG 4'hb
// Field positions inside the address word
`define EE_DEV_TYPE_HI 7
`define EE_DEV_TYPE_LO 4
`define EE_DEV_STRAP 3
`define EE_DEV_TOP 2
`define EE_DEV_SECOND 1
`define EE_DEV_RNW 0
// Bit of the high address byte that must be zero for id page writes
`define EE_ID_LOCK_SEL 2
// Geometry
`define EE_ADDR_W 18
`define EE_PAGE_W 8
`define EE_BITS_PER_WORD 4'h8
// Write cycle time and clock rate; cycles rounded down as a longest time
`define EE_TWR_US 8000
`define EE_CLK_MHZ 10
`define EE_PROG_CYCLES (`EE_TWR_US * `EE_CLK_MHZ)
// Reset values
`define EE_RST_ADDR 18'h0_0000
`define EE_RST_BYTE 8'h00

`endif

// [ee_nvm_store.v]
// Non-volatile store: main array plus the separate identification page.
// Assumes writes come one byte per cycle from the programming sequencer.
`timescale 1ns/1ns
`include "ee_wr_map.vh"

module ee_nvm_store #(
    parameter AW = `EE_ADDR_W
) (
    input wire clk_i,
    input wire rst_i,
    input wire wr_en_i,
    input wire wr_id_i,
    input wire [AW-1:0] wr_addr_i,
    input wire [7:0] wr_data_i,
    input wire [AW-1:0] peek_addr_i,
    input wire peek_id_i,
    output wire [7:0] peek_data_o
);

    // Contents survive reset, as a real array would
    reg [7:0] mem [0:(1<<AW)-1];
    reg [7:0] idm [0:255];
    reg [7:0] peek_q;

    // Byte writes from the sequencer
    always @(posedge clk_i) begin
        if (wr_en_i) begin
            if (wr_id_i) begin
                idm[wr_addr_i[7:0]] <= wr_data_i;
            end else begin
                mem[wr_addr_i] <= wr_data_i;
            end
        end
    end

    // Registered look-in port; stands in for the read path left out here
    always @(posedge clk_i) begin
        if (rst_i) begin
            peek_q <= `EE_RST_BYTE;
        end else if (peek_id_i) begin
            peek_q <= idm[peek_addr_i[7:0]];
        end else begin
            peek_q <= mem[peek_addr_i];
        end
    end

    assign peek_data_o = peek_q;

endmodule

// [ee_wr_engine.v]
// Two-wire EEPROM target: start/stop detect, framing, address decode,
// page buffering and the timed programming cycle.
// Assumes scl_i and sda_i are already synchronous to clk_i and that the
// bus clock is well below the system clock so every edge is seen.
`timescale 1ns/1ns
`include "ee_wr_map.vh"

module ee_wr_engine #(
    parameter AW = `EE_ADDR_W,
    parameter PROG_CYCLES = `EE_PROG_CYCLES
) (
    input wire clk_i,
    input wire rst_i,
    input wire scl_i,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe_o,
    input wire chip_select_strap_i,
    input wire write_protect_i,
    input wire id_page_locked_i,
    input wire [AW-1:0] peek_addr_i,
    input wire peek_id_i,
    output wire [7:0] peek_data_o,
    output wire busy_o,
    output wire standby_o
);

    localparam ST_IDLE = 3'd0;
    localparam ST_DEV = 3'd1;
    localparam ST_AHI = 3'd2;
    localparam ST_ALO = 3'd3;
    localparam ST_DATA = 3'd4;
    localparam ST_ACK = 3'd5;
    localparam ST_WAIT = 3'd6;
    // Last count of the timed cycle, cut to the timer width on purpose
    localparam [31:0] PROG_M1 = PROG_CYCLES - 1;
    localparam [16:0] PROG_LAST = PROG_M1[16:0];

    reg scl_q;
    reg sda_q;
    reg [2:0] st_q;
    reg [2:0] nxt_q;
    reg [3:0] bit_q;
    reg [7:0] sh_q;
    reg ack_q;
    reg ack_drv_q;
    reg oe_q;
    reg id_q;
    reg idbad_q;
    reg wr_q;
    reg [AW-1:0] adr_q;
    reg [255:0] vld_q;
    reg [7:0] pbuf [0:255];
    reg busy_q;
    reg [16:0] tmr_q;
    reg [8:0] cp_q;

    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;
    wire [7:0] rx_byte;
    wire [1:0] hit;
    wire locked_drop;
    wire cp_en;

    // Address word check: bit 1 match, bit 0 id page type
    function [1:0] dev_hit;
        input [7:0] w;
        input strap;
        reg type_ok;
        begin
            type_ok = (w[`EE_DEV_TYPE_HI:`EE_DEV_TYPE_LO] == `EE_TYPE_ARRAY)
                || (w[`EE_DEV_TYPE_HI:`EE_DEV_TYPE_LO] == `EE_TYPE_IDPG);
            dev_hit[1] = type_ok && (w[`EE_DEV_STRAP] == strap);
            dev_hit[0] = (w[`EE_DEV_TYPE_HI:`EE_DEV_TYPE_LO]
                == `EE_TYPE_IDPG);
        end
    endfunction

    // Bus events from the previous and present line levels
    assign scl_rise = scl_i & ~scl_q;
    assign scl_fall = ~scl_i & scl_q;
    assign start_det = scl_i & scl_q & sda_q & ~sda_i;
    assign stop_det = scl_i & scl_q & ~sda_q & sda_i;
    assign rx_byte = {sh_q[6:0], sda_i};
    assign hit = dev_hit(rx_byte, chip_select_strap_i);
    // Data bytes to a locked or wrongly addressed id page are dropped
    assign locked_drop = id_q & (id_page_locked_i | idbad_q);

    // Line history for edge detection
    always @(posedge clk_i) begin
        if (rst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    // Protocol engine and programming timer
    always @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
            nxt_q <= ST_IDLE;
            bit_q <= 4'h0;
            sh_q <= `EE_RST_BYTE;
            ack_q <= 1'b0;
            ack_drv_q <= 1'b0;
            oe_q <= 1'b0;
            id_q <= 1'b0;
            idbad_q <= 1'b0;
            wr_q <= 1'b0;
            adr_q <= `EE_RST_ADDR;
            vld_q <= 256'h0;
            busy_q <= 1'b0;
            tmr_q <= 17'h0_0000;
            cp_q <= 9'h000;
        end else if (busy_q) begin
            // Bus fully ignored while programming, so polls go unanswered
            oe_q <= 1'b0;
            st_q <= ST_IDLE;
            tmr_q <= tmr_q + 17'h0_0001;
            if (!cp_q[8]) begin
                cp_q <= cp_q + 9'h001;
            end
            if (tmr_q == PROG_LAST) begin
                busy_q <= 1'b0;
            end
        end else if (start_det) begin
            // A start aborts anything pending and reopens decoding
            st_q <= ST_DEV;
            bit_q <= 4'h0;
            oe_q <= 1'b0;
            ack_drv_q <= 1'b0;
            wr_q <= 1'b0;
            vld_q <= 256'h0;
        end else if (stop_det) begin
            oe_q <= 1'b0;
            ack_drv_q <= 1'b0;
            st_q <= ST_IDLE;
            // Only a write holding data, and not protected, programs
            if (wr_q && !write_protect_i) begin
                busy_q <= 1'b1;
                tmr_q <= 17'h0_0000;
                cp_q <= 9'h000;
            end
            wr_q <= 1'b0;
        end else begin
            case (st_q)
                ST_DEV, ST_AHI, ST_ALO, ST_DATA: begin
                    if (scl_rise) begin
                        sh_q <= rx_byte;
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == `EE_BITS_PER_WORD - 4'h1) begin
                            ack_q <= 1'b1;
                            ack_drv_q <= 1'b0;
                            st_q <= ST_ACK;
                            case (st_q)
                                ST_DEV: begin
                                    id_q <= hit[0];
                                    adr_q[AW-1:AW-2] <= rx_byte[
                                        `EE_DEV_TOP:`EE_DEV_SECOND];
                                    if (!hit[1]) begin
                                        st_q <= ST_IDLE;
                                    end else if (rx_byte[`EE_DEV_RNW]) begin
                                        // Reads are acked, then parked in ST_WAIT until a start or stop
                                        nxt_q <= ST_WAIT;
                                    end else begin
                                        nxt_q <= ST_AHI;
                                    end
                                end
                                ST_AHI: begin
                                    adr_q[15:8] <= rx_byte;
                                    idbad_q <= rx_byte[`EE_ID_LOCK_SEL];
                                    nxt_q <= ST_ALO;
                                end
                                ST_ALO: begin
                                    adr_q[7:0] <= rx_byte;
                                    nxt_q <= ST_DATA;
                                end
                                default: begin
                                    nxt_q <= ST_DATA;
                                    if (id_q && id_page_locked_i) begin
                                        ack_q <= 1'b0;
                                    end
                                    if (!locked_drop) begin
                                        pbuf[adr_q[7:0]] <= rx_byte;
                                        vld_q[adr_q[7:0]] <= 1'b1;
                                        wr_q <= 1'b1;
                                        // Low byte wraps inside the page
                                        adr_q[7:0] <= adr_q[7:0]
                                            + 8'h01;
                                    end
                                end
                            endcase
                        end
                    end
                end
                ST_ACK: begin
                    // First fall opens the ninth clock, second one ends it
                    if (scl_fall) begin
                        if (!ack_drv_q) begin
                            oe_q <= ack_q;
                            ack_drv_q <= 1'b1;
                        end else begin
                            oe_q <= 1'b0;
                            ack_drv_q <= 1'b0;
                            bit_q <= 4'h0;
                            st_q <= nxt_q;
                        end
                    end
                end
                default: begin
                    st_q <= st_q;
                end
            endcase
        end
    end

    // Copy of buffered bytes into the store early in the timed cycle;
    // 256 cycles fit easily inside the programming time
    assign cp_en = busy_q & ~cp_q[8] & vld_q[cp_q[7:0]];

    ee_nvm_store #(
        .AW(AW)
    ) u_store (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_en_i(cp_en),
        .wr_id_i(id_q),
        .wr_addr_i({adr_q[AW-1:8], cp_q[7:0]}),
        .wr_data_i(pbuf[cp_q[7:0]]),
        .peek_addr_i(peek_addr_i),
        .peek_id_i(peek_id_i),
        .peek_data_o(peek_data_o)
    );

    // Open drain: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe_o = oe_q;
    assign busy_o = busy_q;
    assign standby_o = ~busy_q & (st_q == ST_IDLE);

endmodule

// [ee_wr_engine_monitor.sv]
// Port checker for the two-wire EEPROM write engine.
// Assumes it is bound onto ee_wr_engine; one clock, synchronous reset.
`timescale 1ns/1ns
module ee_wr_mon #(
    parameter AW = 18,
    parameter PROG_CYCLES = 80000
) (
    input wire clk_i,
    input wire rst_i,
    input wire scl_i,
    input wire sda_i,
    input wire sda_oe_o,
    input wire busy_o,
    input wire standby_o
);
    reg scl_q, sda_q, stop_q;
    reg [31:0] busy_cnt_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Stop seen on the lines; launch may lag it by one stage
    always @(posedge clk_i) begin
        scl_q <= scl_i;
        sda_q <= sda_i;
        stop_q <= scl_i & scl_q & sda_i & ~sda_q;
    end
    // Cycles spent programming, cleared while idle
    always @(posedge clk_i) begin
        if (rst_i || !busy_o) begin
            busy_cnt_q <= 32'h0000_0000;
        end else begin
            busy_cnt_q <= busy_cnt_q + 32'h0000_0001;
        end
    end
    sequence s_ack_hold;
        sda_oe_o throughout (##[1:1000] $rose(scl_i) ##1 scl_i);
    endsequence
    sequence s_launch;
        stop_q || $past(stop_q);
    endsequence
    a_ack_holds_pulse: assert property (
        $rose(sda_oe_o) |-> s_ack_hold) else $error("ack dropped early");
    a_drive_clock_low: assert property (
        $changed(sda_oe_o) |-> !scl_i) else $error("data moved, clock high");
    a_quiet_when_busy: assert property (
        busy_o |-> !sda_oe_o) else $error("answer while programming");
    a_prog_time_bound: assert property (
        busy_cnt_q <= PROG_CYCLES + 1) else $error("programming too long");
    a_launch_on_stop: assert property (
        $rose(busy_o) |-> s_launch) else $error("programming without stop");
    a_standby_idle: assert property (
        standby_o |-> !busy_o && !sda_oe_o) else $error("standby not idle");
    a_reset_standby: assert property (
        $fell(rst_i) |-> standby_o && !busy_o && !sda_oe_o)
        else $error("no standby after reset");
    a_ack_not_standby: assert property (
        $rose(sda_oe_o) |-> !standby_o && !busy_o)
        else $error("ack from standby or busy");
endmodule

// [ee_ctl_model.sv]
// Bus controller model: drives the clock line and its share of data.
// Assumes the caller enters each task just after a rising clk_i edge.
`timescale 1ns/1ns
module ee_ctl_model #(
    parameter H = 3
) (
    input wire clk_i,
    input wire sda_i,
    output reg scl_o = 1'b1,
    output reg sda_o = 1'b1
);
    // Half bus period; kept above two system clocks
    task hw;
        repeat (H) @(posedge clk_i);
    endtask
    // Data moves only with the clock low
    task put_bit(input b, output s);
        begin
            sda_o <= b;
            hw;
            scl_o <= 1'b1;
            hw;
            s = sda_i;
            scl_o <= 1'b0;
        end
    endtask
    // Data falls while clock high
    task start;
        begin
            sda_o <= 1'b1;
            hw;
            scl_o <= 1'b1;
            hw;
            sda_o <= 1'b0;
            hw;
            scl_o <= 1'b0;
        end
    endtask
    // Data rises while clock high, clock then rests high
    task stop;
        begin
            sda_o <= 1'b0;
            hw;
            scl_o <= 1'b1;
            hw;
            sda_o <= 1'b1;
            hw;
        end
    endtask
    // Bus recovery: clocks until data reads high, at most nine
    task recover;
        integer i;
        reg s;
        begin
            s = 1'b0;
            i = 0;
            while (!s && i < 9) begin
                put_bit(1'b1, s);
                i = i + 1;
            end
            start;
        end
    endtask
    // Eight bits then a released ninth clock for the ack
    task put_byte(input [7:0] b, output ack);
        integer i;
        reg s;
        begin
            for (i = 7; i >= 0; i = i - 1)
                put_bit(b[i], s);
            put_bit(1'b1, s);
            ack = ~s;
        end
    endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the two-wire EEPROM write engine.
// Assumes ee_ctl_model drives the bus; ee_wr_mon rides along by bind.
`timescale 1ns/1ns
module tb_top;
    localparam PC = 300;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg strap = 1'b0;
    reg wp = 1'b0;
    reg lock = 1'b0;
    reg peek_id = 1'b0;
    reg [17:0] peek_addr = 18'h0_0000;
    wire scl, ctl_sda, sda_o, sda_oe, busy, stby;
    wire [7:0] pk;
    // Open-drain wire with pull-up
    wire sda_w = ctl_sda & (sda_oe ? sda_o : 1'b1);
    integer error_cnt = 0;
    integer n_compared = 0;
    integer seed = 32'h47ff;
    integer t = 0;
    reg [17:0] a;
    reg [7:0] d, dev, o;

    always #50 clk_i = ~clk_i;

    ee_ctl_model i_ee_ctl_model (.clk_i(clk_i), .sda_i(sda_w),
        .scl_o(scl), .sda_o(ctl_sda));
    ee_wr_engine #(.PROG_CYCLES(PC)) i_ee_wr_engine (.clk_i(clk_i),
        .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .chip_select_strap_i(strap),
        .write_protect_i(wp), .id_page_locked_i(lock),
        .peek_addr_i(peek_addr), .peek_id_i(peek_id), .peek_data_o(pk),
        .busy_o(busy), .standby_o(stby));

    function [7:0] pat(input integer i);
        pat = d + i[7:0] + {1'b0, i[8], 6'h00};
    endfunction
    task check(input string what, input [17:0] seen, input [17:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] %0s exp %h seen %h", what, exp, seen);
            end
        end
    endtask
    task send(input [7:0] b, input exp_ack);
        reg ack;
        begin
            i_ee_ctl_model.put_byte(b, ack);
            check("ack", ack, exp_ack);
        end
    endtask
    // Address, two address bytes, n pattern bytes, stop; reads stop early
    task xfer(input [7:0] dv, input [15:0] ad, input integer n,
        input [1:0] ea);
        integer i;
        begin
            i_ee_ctl_model.start;
            send(dv, ea[1]);
            if (ea[1] && !dv[0]) begin
                send(ad[15:8], 1'b1);
                send(ad[7:0], 1'b1);
                for (i = 0; i < n; i = i + 1)
                    send(pat(i), ea[0]);
            end
            i_ee_ctl_model.stop;
        end
    endtask
    // Poll during the cycle, then wait a bounded time for standby
    task prog(input chk, input eb);
        integer i;
        reg ack;
        begin
            repeat (3) @(posedge clk_i);
            if (chk) check("busy", busy, eb);
            i_ee_ctl_model.start;
            i_ee_ctl_model.put_byte(dev, ack);
            i_ee_ctl_model.stop;
            if (chk) check("poll", ack, !eb);
            i = 0;
            while (stby !== 1'b1 && i < PC + 50) begin
                @(posedge clk_i);
                i = i + 1;
            end
            check("standby", stby, 1'b1);
            t = t + 1;
            $display("test %0d done", t);
        end
    endtask
    task peek(input id, input [17:0] ad, input [7:0] exp);
        begin
            peek_id <= id;
            peek_addr <= ad;
            repeat (3) @(posedge clk_i);
            check("store", pk, exp);
        end
    endtask
    task results;
        begin
            $display("compared %0d mismatches %0d", n_compared, error_cnt);
            if (error_cnt == 0 && n_compared > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    // Longest run is the 258-byte page load, well under this span
    initial begin
        repeat (60000) @(posedge clk_i);
        error_cnt = error_cnt + 1;
        results;
    end

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("stby rst", stby, 1'b1);
        check("peek rst", pk, 8'h00);
        check("sda value", sda_o, 1'b0);
        // Recovery clocks and start before the first command
        i_ee_ctl_model.recover;
        // Random byte writes, random strap level
        repeat (3) begin
            a = $random(seed);
            d = $random(seed);
            strap <= a[0];
            @(posedge clk_i);
            dev = {4'ha, strap, a[17:16], 1'b0};
            xfer(dev, a[15:0], 1, 2'b11);
            prog(1'b1, 1'b1);
            peek(1'b0, a, d);
        end
        // Page load crossing the page end twice: wrap and overwrite
        a[7:0] = 8'hff;
        xfer(dev, a[15:0], 258, 2'b11);
        prog(1'b1, 1'b1);
        peek(1'b0, a, pat(256));
        peek(1'b0, {a[17:8], 8'h00}, pat(257));
        peek(1'b0, {a[17:8], 8'h01}, pat(2));
        // Foreign strap, foreign type, then a read request
        xfer(dev ^ 8'h08, a[15:0], 1, 2'b00);
        prog(1'b1, 1'b0);
        xfer(dev ^ 8'h30, a[15:0], 1, 2'b00);
        prog(1'b1, 1'b0);
        xfer(dev | 8'h01, a[15:0], 1, 2'b10);
        prog(1'b1, 1'b0);
        // Protected write: acked, no cycle, contents kept
        o = pat(256);
        wp <= 1'b1;
        d = d + 8'h5a;
        xfer(dev, a[15:0], 1, 2'b11);
        prog(1'b1, 1'b0);
        peek(1'b0, a, o);
        wp <= 1'b0;
        // Id page write, then refused once locked
        a[10] = 1'b0;
        dev = {4'hb, strap, a[17:16], 1'b0};
        xfer(dev, a[15:0], 1, 2'b11);
        prog(1'b1, 1'b1);
        peek(1'b1, a, d);
        o = d;
        // Bit ten set: bytes acked but dropped, no cycle
        d = d + 8'h33;
        a[10] = 1'b1;
        xfer(dev, a[15:0], 1, 2'b11);
        prog(1'b1, 1'b0);
        peek(1'b1, a, o);
        a[10] = 1'b0;
        lock <= 1'b1;
        d = d ^ 8'hff;
        xfer(dev, a[15:0], 1, 2'b10);
        prog(1'b1, 1'b0);
        peek(1'b1, a, o);
        results;
    end
endmodule

bind ee_wr_engine ee_wr_mon #(.AW(AW), .PROG_CYCLES(PROG_CYCLES))
    i_ee_wr_mon (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i),
    .sda_i(sda_i), .sda_oe_o(sda_oe_o), .busy_o(busy_o),
    .standby_o(standby_o));
